// [hw/mswt_pkg.sv]
/*
  Package for the microstep wave table, low words: register indices, reset
  contents, width codes and own register offsets.
  Assumes an AXI4-Lite master with 32-bit data; byte address = 4 * index.
*/
package mswt_pkg;
  localparam int unsigned MSWT_DW = 32;
  localparam int unsigned MSWT_AW = 12;
  localparam int unsigned MSWT_AMP_W = 9;
  localparam int unsigned MSWT_POS_W = 7;
  // Register indices
  localparam logic [7:0] MSWT_IDX_WORD0 = 8'h60;
  localparam logic [7:0] MSWT_IDX_WORD1 = 8'h61;
  localparam logic [7:0] MSWT_IDX_WORD2 = 8'h62;
  localparam logic [7:0] MSWT_IDX_SEG = 8'h70;
  localparam logic [7:0] MSWT_IDX_START = 8'h71;
  localparam logic [7:0] MSWT_IDX_POS = 8'h72;
  localparam logic [7:0] MSWT_IDX_CUR = 8'h73;
  // Reset contents: sine table words, other registers zero
  localparam logic [31:0] MSWT_RST_WORD0 = 32'haaaa_b554;
  localparam logic [31:0] MSWT_RST_WORD1 = 32'h4a95_54aa;
  localparam logic [31:0] MSWT_RST_WORD2 = 32'h2449_2929;
  localparam logic [31:0] MSWT_RST_SEG = 32'h0000_0000;
  localparam logic [31:0] MSWT_RST_START = 32'h0000_0000;
  localparam logic [31:0] MSWT_RST_POS = 32'h0000_0000;
  // Field positions
  localparam int unsigned MSWT_SEG_W0_LSB = 0;
  localparam int unsigned MSWT_SEG_W1_LSB = 2;
  localparam int unsigned MSWT_SEG_W2_LSB = 4;
  localparam int unsigned MSWT_START_A_LSB = 0;
  localparam int unsigned MSWT_START_B_LSB = 16;
  localparam int unsigned MSWT_PHASE_A_CURRENT_LSB = 0;
  localparam int unsigned MSWT_PHASE_B_CURRENT_LSB = 16;
  // AXI responses
  localparam logic [1:0] MSWT_RESP_OKAY = 2'b00;
  localparam logic [1:0] MSWT_RESP_SLVERR = 2'b10;
  // Width codes
  typedef enum logic [1:0] {
    MSWT_W_DN1 = 2'b00,
    MSWT_W_Z = 2'b01,
    MSWT_W_UP1 = 2'b10,
    MSWT_W_UP2 = 2'b11
  } mswt_width_t;
endpackage : mswt_pkg

// [hw/mswt_step_dec.sv]
/*
  Decoder turning one table bit and its width code into a signed step.
  Assumes the width code is stable while the bit is in use.
*/
`timescale 1ns/1ps
`default_nettype none
module mswt_step_dec
  import mswt_pkg::*;
(
  input wire logic tbl_bit,
  input wire logic [1:0] width_code,
  output logic signed [2:0] step
);
  // Base step per width code, one more when the bit is set
  always_comb begin
    case (width_code)
      MSWT_W_DN1: step = 3'sb111;
      MSWT_W_Z: step = 3'sb000;
      MSWT_W_UP1: step = 3'sb001;
      MSWT_W_UP2: step = 3'sb010;
      default: step = 3'sb000;
    endcase
    if (tbl_bit) begin
      step = step + 3'sb001;
    end
  end
endmodule // mswt_step_dec
`default_nettype wire

// [hw/mswt_table_low.sv]
/*
  Microstep wave table, low three words, with an AXI4-Lite slave and a
  quarter-wave accumulator that walks entries 0 to 95 toward a target
  position.  Assumes one write and one read outstanding at a time.
*/
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module mswt_table_low
  import mswt_pkg::*;
#(
  parameter int unsigned ENTRIES = 96
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [MSWT_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [MSWT_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [MSWT_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [MSWT_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [MSWT_AMP_W-1:0] phase_a_current,
  output logic [MSWT_AMP_W-1:0] phase_b_current,
  output logic walk_done
);
  // Table storage, three words flattened to one bit vector
  logic [31:0] word_q [3];
  logic [31:0] word_d [3];
  logic [31:0] seg_q, seg_d, start_q, start_d, pos_q, pos_d;
  // Write channel state
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [MSWT_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  // Read channel state
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // Walker state
  logic [MSWT_POS_W-1:0] idx_q, idx_d;
  logic signed [MSWT_AMP_W+1:0] acc_q, acc_d;
  logic [MSWT_AMP_W-1:0] phase_a_current_q, phase_a_current_d, phase_b_current_q, phase_b_current_d;
  logic done_q, done_d;
  logic [95:0] tbl_bits;
  logic [1:0] width_now;
  logic signed [2:0] step_now;
  logic [MSWT_POS_W-1:0] target;
  logic [7:0] aw_idx, ar_idx;
  logic do_write;

  // Entry n sits at bit n mod 32 of word n/32, so bit 31 of word 2 is the top entry
  assign tbl_bits = {word_q[2], word_q[1], word_q[0]};
  assign aw_idx = awaddr_q[9:2];
  assign ar_idx = s_axi_araddr[9:2];
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  // Target beyond the quarter in the low 7 bits of pos is clamped, the table covers no more
  assign target = (pos_q[MSWT_POS_W-1:0] >= ENTRIES[MSWT_POS_W-1:0]) ?
    MSWT_POS_W'(ENTRIES - 1) : pos_q[MSWT_POS_W-1:0];
  // Segment of the entry picks its width code
  always_comb begin
    case (idx_q[6:5])
      2'd0: width_now = seg_q[MSWT_SEG_W0_LSB +: 2];
      2'd1: width_now = seg_q[MSWT_SEG_W1_LSB +: 2];
      default: width_now = seg_q[MSWT_SEG_W2_LSB +: 2];
    endcase
  end

  mswt_step_dec u_dec (
    .tbl_bit(tbl_bits[idx_q]),
    .width_code(width_now),
    .step(step_now)
  );

  // Write path: address and data taken in either order, answer after both
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    for (int i = 0; i < 3; i++) begin
      word_d[i] = word_q[i];
    end
    seg_d = seg_q;
    start_d = start_q;
    pos_d = pos_q;
    // Take a channel only on its own handshake, so a held valid is never taken twice
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = MSWT_RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b]) begin
          case (aw_idx)
            MSWT_IDX_WORD0: word_d[0][b*8 +: 8] = wdata_q[b*8 +: 8];
            MSWT_IDX_WORD1: word_d[1][b*8 +: 8] = wdata_q[b*8 +: 8];
            MSWT_IDX_WORD2: word_d[2][b*8 +: 8] = wdata_q[b*8 +: 8];
            MSWT_IDX_SEG: seg_d[b*8 +: 8] = wdata_q[b*8 +: 8];
            MSWT_IDX_START: start_d[b*8 +: 8] = wdata_q[b*8 +: 8];
            MSWT_IDX_POS: pos_d[b*8 +: 8] = wdata_q[b*8 +: 8];
            default: bresp_d = MSWT_RESP_SLVERR;
          endcase
        end
      end
      if (!(aw_idx inside {MSWT_IDX_WORD0, MSWT_IDX_WORD1, MSWT_IDX_WORD2,
          MSWT_IDX_SEG, MSWT_IDX_START, MSWT_IDX_POS})) begin
        bresp_d = MSWT_RESP_SLVERR;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // Read path: one cycle from address to data
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = MSWT_RESP_OKAY;
      case (ar_idx)
        MSWT_IDX_WORD0: rdata_d = word_q[0];
        MSWT_IDX_WORD1: rdata_d = word_q[1];
        MSWT_IDX_WORD2: rdata_d = word_q[2];
        MSWT_IDX_SEG: rdata_d = seg_q;
        MSWT_IDX_START: rdata_d = start_q;
        MSWT_IDX_POS: rdata_d = pos_q;
        MSWT_IDX_CUR: rdata_d = {7'd0, phase_b_current_q, 7'd0, phase_a_current_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = MSWT_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Walker: one entry per clock, restarts on any change of table or target
  always_comb begin
    idx_d = idx_q;
    acc_d = acc_q;
    phase_a_current_d = phase_a_current_q;
    phase_b_current_d = phase_b_current_q;
    done_d = done_q;
    if (do_write) begin
      idx_d = '0;
      acc_d = (MSWT_AMP_W+2)'(start_q[MSWT_START_A_LSB +: MSWT_AMP_W]);
      done_d = 1'b0;
    end else if (!done_q) begin
      if (idx_q == target) begin
        done_d = 1'b1;
        if (target == '0) begin
          phase_a_current_d = start_q[MSWT_START_A_LSB +: MSWT_AMP_W];
        end else if (acc_q < 0) begin
          phase_a_current_d = '0;
        end else begin
          phase_a_current_d = acc_q[MSWT_AMP_W-1:0];
        end
        phase_b_current_d = start_q[MSWT_START_B_LSB +: MSWT_AMP_W];
      end else begin
        acc_d = acc_q + (MSWT_AMP_W+2)'(step_now);
        idx_d = idx_q + 1'b1;
      end
    end
  end

  // Registers; reset loads the sine table
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_q[0] <= MSWT_RST_WORD0;
      word_q[1] <= MSWT_RST_WORD1;
      word_q[2] <= MSWT_RST_WORD2;
      seg_q <= MSWT_RST_SEG;
      start_q <= MSWT_RST_START;
      pos_q <= MSWT_RST_POS;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= MSWT_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= MSWT_RESP_OKAY;
      idx_q <= '0;
      acc_q <= '0;
      phase_a_current_q <= '0;
      phase_b_current_q <= '0;
      done_q <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        word_q[i] <= word_d[i];
      end
      seg_q <= seg_d;
      start_q <= start_d;
      pos_q <= pos_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      idx_q <= idx_d;
      acc_q <= acc_d;
      phase_a_current_q <= phase_a_current_d;
      phase_b_current_q <= phase_b_current_d;
      done_q <= done_d;
    end
  end

  // Ready flags are flops: awready and wready low while their word is held, arready low while a read answer waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_d && !s_axi_awready;
      s_axi_wready <= !w_held_d && !s_axi_wready;
      s_axi_arready <= !rvalid_d && !s_axi_arready && s_axi_arvalid;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign phase_a_current = phase_a_current_q;
  assign phase_b_current = phase_b_current_q;
  assign walk_done = done_q;
endmodule // mswt_table_low
`default_nettype wire

// [verif/mswt_monitor.sv]
/*
  Checker for the low wave table block: bus answers and reset state.
  Assumes it is bound to mswt_table_low and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module mswt_monitor
  import mswt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_arvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [MSWT_DW-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [MSWT_AMP_W-1:0] phase_a_current,
  input wire logic walk_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // One answer per request, then it drops
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  // Answers come within a few cycles of the request
  b_answer_a: assert property ($rose(s_axi_awvalid) |-> ##[1:8] s_axi_bvalid)
    else $error("write answer late");
  r_answer_a: assert property ($rose(s_axi_arvalid) |-> ##[1:4] s_axi_rvalid)
    else $error("read answer late");
  // Refused reads carry no stale data; write answers are OKAY or SLVERR
  r_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == MSWT_RESP_SLVERR
    |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read has data");
  b_legal_a: assert property (s_axi_bvalid
    |-> s_axi_bresp == MSWT_RESP_OKAY || s_axi_bresp == MSWT_RESP_SLVERR)
    else $error("bad write response");
  // Outputs come out of reset quiet
  rst_quiet_a: assert property ($rose(aresetn)
    |-> !s_axi_bvalid && !s_axi_rvalid && !walk_done)
    else $error("outputs busy after reset");
  rst_amp_a: assert property ($rose(aresetn) |-> phase_a_current == 9'h000)
    else $error("amplitude not cleared");
endmodule // mswt_monitor
bind mswt_table_low mswt_monitor mswt_monitor_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_arvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phase_a_current, .walk_done);
`default_nettype wire

// [verif/tb_mswt_table_low.sv]
/*
  Directed bench for the low wave table: access, refusals, walks.
  Assumes the package constants and a 25 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_mswt_table_low
  import mswt_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = '1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, walk_done;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [8:0] phase_a_current, phase_b_current;
  // Mirror of the table, kept in step with every write
  logic [95:0] tbl = {MSWT_RST_WORD2, MSWT_RST_WORD1, MSWT_RST_WORD0};
  logic [5:0] segs [4] = '{6'h24, 6'h3f, 6'h1b, 6'h00};
  logic [8:0] sta [4] = '{9'h040, 9'h020, 9'h080, 9'h055};
  int tgt [4] = '{95, 100, 40, 0};
  int n_errors = 0, checks_done = 0;
  initial forever #12.5 aclk = ~aclk;
  mswt_table_low mswt_table_low_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .phase_a_current, .phase_b_current, .walk_done);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Address and data offered together; an extra edge keeps drivers apart
  task automatic wck(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge aclk);
    chk({30'h0, resp}, {30'h0, er});
  endtask
  // Data comes the cycle after the address is taken, so track both
  task automatic rck(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ad, dd;
    ad = 0;
    dd = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (s_axi_arready === 1 && !ad) begin
        ad = 1;
        s_axi_arvalid <= 0;
      end
      if (s_axi_rvalid === 1 && !dd) begin
        dd = 1;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
      end
    end
    @(posedge aclk);
    chk(rd, e);
    chk({30'h0, resp}, {30'h0, er});
  endtask
  function automatic logic [31:0] amp(logic [5:0] s, logic [8:0] a, int n);
    int v;
    int w;
    v = a;
    for (int i = 0; i < (n > 95 ? 95 : n); i++) begin
      w = s[2*(i/32)+:2];
      v = v + w - 1 + int'(tbl[i]);
    end
    // Clamped once at the end, like the walker; no upper clamp
    if (v < 0) v = 0;
    return {23'h0, v[8:0]};
  endfunction
  // Target written last so the walk starts from the new start value
  task automatic wal(input logic [5:0] s, input logic [8:0] a, input int n);
    logic [8:0] b;
    logic [31:0] ea;
    b = ~a;
    ea = amp(s, a, n);
    wck(12'h1c4, {7'h0, b, 7'h0, a}, 4'hf, MSWT_RESP_OKAY);
    wck(12'h1c0, {26'h0, s}, 4'hf, MSWT_RESP_OKAY);
    wck(12'h1c8, 32'(n), 4'hf, MSWT_RESP_OKAY);
    repeat (n + 4) @(posedge aclk);
    while (walk_done !== 1) @(posedge aclk);
    chk({23'h0, phase_a_current}, ea);
    chk({23'h0, phase_b_current}, {23'h0, b});
    rck(12'h1cc, {7'h0, b, ea[15:0]}, MSWT_RESP_OKAY);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rck(12'h180, MSWT_RST_WORD0, MSWT_RESP_OKAY);
    rck(12'h184, MSWT_RST_WORD1, MSWT_RESP_OKAY);
    rck(12'h188, MSWT_RST_WORD2, MSWT_RESP_OKAY);
    $display("test reset values done");
    wck(12'h180, 32'h0000_ffff, 4'hf, MSWT_RESP_OKAY);
    rck(12'h180, 32'h0000_ffff, MSWT_RESP_OKAY);
    wck(12'h184, 32'hffff_ffff, 4'h1, MSWT_RESP_OKAY);
    rck(12'h184, {MSWT_RST_WORD1[31:8], 8'hff}, MSWT_RESP_OKAY);
    wck(12'h3fc, 32'h1234_5678, 4'hf, MSWT_RESP_SLVERR);
    rck(12'h3fc, 32'h0000_0000, MSWT_RESP_SLVERR);
    wck(12'h1cc, 32'h1234_5678, 4'hf, MSWT_RESP_SLVERR);
    rck(12'h188, MSWT_RST_WORD2, MSWT_RESP_OKAY);
    tbl[31:0] = 32'h0000_ffff;
    tbl[39:32] = 8'hff;
    $display("test access done");
    for (int k = 0; k < 4; k++) wal(segs[k], sta[k], tgt[k]);
    $display("test walks done");
    print_verdict();
  end
endmodule // tb_mswt_table_low
`default_nettype wire
